// [verification/analog_input_select_tb.sv]
`timescale 1ns/1ps
module analog_input_select_tb;
  import amux_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  bus_req_t busReq = '0;
  conv_result_t convResult = '0;
  logic [7:0] rdata;
  logic [31:0] analogSel, digitalKeep, analogPinSelected, ex;
  logic [7:0] sel, r;
  logic [11:0] d;
  int mismatches = 0;
  int checked = 0;
  int seed = 7;
  int modelSel = 0;
  int modelCfg = 0;
  int modelData = 0;
  int modelDiff = 0;
  logic [7:0] expq[$];
  always #50 clk = ~clk;
  analog_input_select u_analog_input_select(.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .busReq(busReq), .rdata(rdata), .convResult(convResult), .analogSel(analogSel),
    .digitalKeep(digitalKeep), .analogPinSelected(analogPinSelected));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkRead(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s read %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] modelRoute();
    logic [31:0] m;
    m = '0;
    if (modelSel[5]) m[modelSel[4:3] * PinsPerPort + modelSel[2:0]] = 1'b1;
    return m;
  endfunction
  function automatic logic [7:0] modelRead(input logic [7:0] a);
    logic [11:0] w;
    w = modelData[11:0];
    if (a == SelectOffset) return modelSel[7:0];
    if (a == ConfigOffset) return modelCfg[7:0];
    if (a == ResultHighOffset && modelCfg[0]) return w[11:4];
    if (a == ResultHighOffset) return {{4{modelDiff[0] & w[11]}}, w[11:8]};
    if (a == ResultLowOffset && modelCfg[0]) return {w[3:0], 4'h0};
    if (a == ResultLowOffset) return w[7:0];
    return 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    busReq.addr <= a;
    busReq.wdata <= v;
    busReq.wr <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
    if (clkEn && resetn) begin
      if (a == SelectOffset) modelSel = int'(v[5:0]);
      if (a == ConfigOffset) modelCfg = int'(v[1:0]);
      if (a == ResultHighOffset && modelCfg[0]) modelData[11:4] = v;
      if (a == ResultHighOffset && !modelCfg[0]) modelData[11:8] = v[3:0];
      if (a == ResultLowOffset && modelCfg[0]) modelData[3:0] = v[7:4];
      if (a == ResultLowOffset && !modelCfg[0]) modelData[7:0] = v;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    expq.push_back(modelRead(a));
    #1 v = rdata;
  endtask
  task print_verdict;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    #1 chk(analogSel, '0, "reset routing");
    chk(digitalKeep, '1, "reset keep");
    rd(ResultHighOffset, r);
    chkRead(r, expq.pop_front(), "reset high");
    // Index sweeps enable, every port and every pin; bits 7:6 random
    for (int i = 0; i < 64; i++) begin
      sel = 8'($random(seed));
      sel[5:0] = i[5:0];
      wr(SelectOffset, sel);
      @(posedge clk);
      #1 ex = modelRoute();
      chk(analogSel, ex, "routing");
      chk(analogPinSelected, ex, "pin selected");
      chk(digitalKeep, ~ex, "gpio keep");
      rd(SelectOffset, r);
      chkRead(r, expq.pop_front(), "select readback");
    end
    // Enable low: a write is ignored and routing holds still
    @(posedge clk);
    clkEn <= 1'b0;
    wr(SelectOffset, 8'h00);
    @(posedge clk);
    #1 chk(analogSel, modelRoute(), "frozen routing");
    @(posedge clk);
    clkEn <= 1'b1;
    rd(SelectOffset, r);
    chkRead(r, expq.pop_front(), "frozen select");
    // Reset in mid-run returns routing and registers to idle
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    modelSel = 0;
    modelCfg = 0;
    modelData = 0;
    modelDiff = 0;
    #1 chk(analogSel, '0, "rerun routing");
    chk(digitalKeep, '1, "rerun keep");
    rd(SelectOffset, r);
    chkRead(r, expq.pop_front(), "rerun select");
    for (int i = 0; i < 8; i++) begin
      d = 12'($random(seed));
      d[11] = i[2];
      wr(ConfigOffset, {6'h00, i[1:0]});
      @(posedge clk);
      convResult <= '{valid: 1'b1, differential: i[1], data: d};
      @(posedge clk);
      convResult.valid <= 1'b0;
      modelData = int'(d);
      modelDiff = int'(i[1]);
      rd(ResultHighOffset, r);
      chkRead(r, expq.pop_front(), "result high");
      rd(ResultLowOffset, r);
      chkRead(r, expq.pop_front(), "result low");
      wr(ResultLowOffset, d[7:0] ^ 8'h5a);
      rd(ResultHighOffset, r);
      chkRead(r, expq.pop_front(), "high after low write");
      rd(ResultLowOffset, r);
      chkRead(r, expq.pop_front(), "low after write");
    end
    wr(8'h10, 8'hff);
    rd(8'h10, r);
    chkRead(r, expq.pop_front(), "unmapped read");
    print_verdict;
  end
endmodule

// [verilog/amux_pkg.sv]
package amux_pkg;
  localparam logic [7:0] SelectOffset = 8'hbb;
  localparam logic [7:0] ResultHighOffset = 8'hbf;
  localparam logic [7:0] ResultLowOffset = 8'hbe;
  localparam logic [7:0] ConfigOffset = 8'hbd;
  localparam logic [7:0] SelectReset = 8'h00;
  localparam logic [7:0] ResultReset = 8'h00;
  localparam logic [7:0] ConfigReset = 8'h00;
  localparam int EnableBit = 5;
  localparam int AlignBit = 0;
  localparam int DiffBit = 1;
  localparam int NumPorts = 4;
  localparam int PinsPerPort = 8;

  typedef struct packed {
    logic [1:0] unused;
    logic enable;
    logic [1:0] port;
    logic [2:0] pin;
  } select_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic differential;
    logic [11:0] data;
  } conv_result_t;
endpackage

// [verilog/analog_input_select.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module analog_input_select
  import amux_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire amux_pkg::bus_req_t busReq,
  output logic [7:0] rdata,
  input wire amux_pkg::conv_result_t convResult,
  output logic [NumPorts*PinsPerPort-1:0] analogSel,
  output logic [NumPorts*PinsPerPort-1:0] digitalKeep,
  output logic [NumPorts*PinsPerPort-1:0] analogPinSelected
);
  import amux_pkg::*;

  select_t sel_q;
  logic [7:0] cfg_q;
  logic [11:0] result_q;
  logic resultDiff_q;
  logic [7:0] rdata_q;
  logic [NumPorts*PinsPerPort-1:0] route_q;
  logic [NumPorts*PinsPerPort-1:0] route_d;
  logic [NumPorts*PinsPerPort-1:0] keep_q;
  logic [4:0] selIndex;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;

  function automatic logic [4:0] pinIndex(input select_t s);
    pinIndex = {s.port, s.pin};
  endfunction

  function automatic logic writeHit(input bus_req_t r, input logic [7:0] offset);
    writeHit = r.wr && (r.addr == offset);
  endfunction

  function automatic logic readHit(input bus_req_t r, input logic [7:0] offset);
    readHit = r.rd && (r.addr == offset);
  endfunction

  assign selIndex = pinIndex(sel_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= SelectReset;
    end else if (clkEn && writeHit(busReq, SelectOffset)) begin
      sel_q <= {2'h0, busReq.wdata[5:0]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= ConfigReset;
    end else if (clkEn && writeHit(busReq, ConfigOffset)) begin
      cfg_q <= {6'h00, busReq.wdata[1:0]};
    end
  end

  // Converter result wins over a software write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_q <= 12'h000;
      resultDiff_q <= 1'b0;
    end else if (clkEn) begin
      if (convResult.valid) begin
        result_q <= convResult.data;
        resultDiff_q <= convResult.differential;
      end else if (writeHit(busReq, ResultHighOffset)) begin
        if (cfg_q[AlignBit]) begin
          result_q[11:4] <= busReq.wdata;
        end else begin
          result_q[11:8] <= busReq.wdata[3:0];
        end
      end else if (writeHit(busReq, ResultLowOffset)) begin
        if (cfg_q[AlignBit]) begin
          result_q[3:0] <= busReq.wdata[7:4];
        end else begin
          result_q[7:0] <= busReq.wdata;
        end
      end
    end
  end

  always_comb begin
    if (cfg_q[AlignBit]) begin
      resultHigh = result_q[11:4];
      resultLow = {result_q[3:0], 4'h0};
    end else begin
      resultHigh = {{4{resultDiff_q & result_q[11]}}, result_q[11:8]};
      resultLow = result_q[7:0];
    end
  end

  // Single-hot routing; a port write alone never widens it to the whole port
  always_comb begin
    route_d = '0;
    if (sel_q.enable) begin
      route_d[selIndex] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      route_q <= '0;
    end else if (clkEn) begin
      route_q <= route_d;
    end
  end

  // Own flop so the keep outputs come straight from a register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keep_q <= '1;
    end else if (clkEn) begin
      keep_q <= ~route_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clkEn) begin
      if (busReq.rd) begin
        unique case (busReq.addr)
          SelectOffset: rdata_q <= sel_q;
          ResultHighOffset: rdata_q <= resultHigh;
          ResultLowOffset: rdata_q <= resultLow;
          ConfigOffset: rdata_q <= cfg_q;
          default: rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign rdata = rdata_q;
  assign analogSel = route_q;
  assign analogPinSelected = route_q;
  assign digitalKeep = keep_q;

  // Routing and keep outputs
  a_single_pin: assert property (@(posedge clk) disable iff (!resetn)
    $countones(route_q) <= 1)
    else $error("more than one pin routed");
  a_disable_none: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && !sel_q.enable |=> route_q == '0)
    else $error("pin routed while disabled");
  a_route_index: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && sel_q.enable |=> route_q[$past(selIndex)])
    else $error("wrong pin routed");
  a_pin_decode: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && sel_q.enable |=> route_q[PinsPerPort*$past(sel_q.port) + $past(sel_q.pin)])
    else $error("pin field decode wrong");
  a_one_port: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && sel_q.enable
    |=> route_q == ({{(NumPorts*PinsPerPort-1){1'b0}}, 1'b1} << $past(selIndex)))
    else $error("route not exactly one pin");
  a_others_digital: assert property (@(posedge clk) disable iff (!resetn)
    (digitalKeep ^ route_q) == '1)
    else $error("digital keep mismatch");
  a_keep_routed: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && sel_q.enable
    |=> !digitalKeep[$past(selIndex)])
    else $error("routed pin still kept digital");
  a_keep_count: assert property (@(posedge clk) disable iff (!resetn)
    $countones(digitalKeep) >= NumPorts*PinsPerPort - 1)
    else $error("too few pins kept digital");
  a_enable_freeze: assert property (@(posedge clk) disable iff (!resetn)
    !clkEn |=> $stable(route_q) && $stable(keep_q) && $stable(rdata_q))
    else $error("state moved while clock enable low");

  // Read port, converter result load and select write
  a_left_high: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultHighOffset) && cfg_q[AlignBit]
    |=> rdata == $past(result_q[11:4]))
    else $error("left aligned high wrong");
  a_right_high: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultHighOffset) && !cfg_q[AlignBit]
    |=> rdata[3:0] == $past(result_q[11:8]))
    else $error("right aligned high nibble wrong");
  a_low_align: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultLowOffset) && cfg_q[AlignBit]
    |=> rdata[3:0] == 4'h0)
    else $error("left aligned low nibble not zero");
  a_left_low: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultLowOffset) && cfg_q[AlignBit]
    |=> rdata[7:4] == $past(result_q[3:0]))
    else $error("left aligned low upper nibble wrong");
  a_right_low: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultLowOffset) && !cfg_q[AlignBit]
    |=> rdata == $past(result_q[7:0]))
    else $error("right aligned low wrong");
  a_sign_ext: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultHighOffset) && !cfg_q[AlignBit]
    |=> rdata[7:4] == {4{$past(resultDiff_q) & rdata[3]}})
    else $error("upper nibble extension wrong");
  a_single_zero: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ResultHighOffset) && !cfg_q[AlignBit] && !resultDiff_q
    |=> rdata[7:4] == 4'h0)
    else $error("single ended upper nibble not zero");
  a_result_load: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && convResult.valid |=> result_q == $past(convResult.data))
    else $error("converter result not loaded");
  a_select_write: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && writeHit(busReq, SelectOffset)
    |=> sel_q == {2'b00, $past(busReq.wdata[5:0])})
    else $error("select write not stored");
  a_select_read: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, SelectOffset)
    |=> rdata == {2'b00, $past(sel_q[5:0])})
    else $error("select readback wrong");
  a_config_read: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && readHit(busReq, ConfigOffset) |=> rdata[7:2] == 6'h00)
    else $error("config upper bits not zero");
  a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && !busReq.rd |=> rdata == 8'h00)
    else $error("read data without a read");
endmodule
